// >>> verilog/pief_pkg.sv
`default_nettype none

package pief_pkg;

    // Register byte offsets on the bus
    localparam logic [7:0] PIEF_ADR_PENDING = 8'h0c;
    localparam logic [7:0] PIEF_ADR_ENABLE = 8'h8c;
    localparam logic [7:0] PIEF_ADR_CONTROL = 8'h10;
    localparam logic [7:0] PIEF_ADR_EVT_STATUS = 8'h14;
    localparam logic [7:0] PIEF_ADR_EVT_MASK = 8'h18;

    // Source bit positions, shared by enable, pending, status and mask
    localparam int PIEF_BIT_PARALLEL = 7;
    localparam int PIEF_BIT_RESERVED = 6;
    localparam int PIEF_BIT_SERIAL_RX = 5;
    localparam int PIEF_BIT_SERIAL_TX = 4;
    localparam int PIEF_BIT_SYNC_SERIAL = 3;
    localparam int PIEF_BIT_CAPCMP = 2;
    localparam int PIEF_BIT_PERIOD_MATCH = 1;
    localparam int PIEF_BIT_OVERFLOW = 0;

    // Control register gating bits
    localparam int PIEF_BIT_GLOBAL_EN = 7;
    localparam int PIEF_BIT_PERIPH_MASTER_EN = 6;

    // Bits that hold a flag; the reserved slot never latches
    localparam logic [7:0] PIEF_SOURCE_MASK = 8'hbf;
    localparam logic [7:0] PIEF_CONTROL_MASK = 8'hc0;

    // Reset values
    localparam logic [7:0] PIEF_RST_ENABLE = 8'h00;
    localparam logic [7:0] PIEF_RST_PENDING = 8'h00;
    localparam logic [7:0] PIEF_RST_CONTROL = 8'h00;
    localparam logic [7:0] PIEF_RST_EVT_STATUS = 8'h00;
    localparam logic [7:0] PIEF_RST_EVT_MASK = 8'h00;

    typedef enum logic [2:0] {
        PIEF_REG_NONE,
        PIEF_REG_PENDING,
        PIEF_REG_ENABLE,
        PIEF_REG_CONTROL,
        PIEF_REG_EVT_STATUS,
        PIEF_REG_EVT_MASK
    } pief_reg_t;

    function automatic pief_reg_t pief_decode(input logic [7:0] adr);
        pief_reg_t r;
        r = PIEF_REG_NONE;
        if (adr[7:2] == PIEF_ADR_PENDING[7:2]) begin
            r = PIEF_REG_PENDING;
        end else if (adr[7:2] == PIEF_ADR_ENABLE[7:2]) begin
            r = PIEF_REG_ENABLE;
        end else if (adr[7:2] == PIEF_ADR_CONTROL[7:2]) begin
            r = PIEF_REG_CONTROL;
        end else if (adr[7:2] == PIEF_ADR_EVT_STATUS[7:2]) begin
            r = PIEF_REG_EVT_STATUS;
        end else if (adr[7:2] == PIEF_ADR_EVT_MASK[7:2]) begin
            r = PIEF_REG_EVT_MASK;
        end
        return r;
    endfunction : pief_decode

endpackage : pief_pkg

`default_nettype wire

// >>> verilog/pief_wb_slave.sv
`default_nettype none

module pief_wb_slave
    import pief_pkg::*;
(
    input wire logic clk_i,          // Core clock
    input wire logic rst_i,          // Synchronous reset
    input wire logic wb_cyc_i,       // Bus cycle
    input wire logic wb_stb_i,       // Strobe
    input wire logic [7:0] wb_adr_i, // Byte address
    output logic wb_ack_o,           // Acknowledge
    output logic acc_o,              // One-cycle access pulse
    output pief_reg_t sel_reg_o      // Decoded register
);

    typedef struct packed {
        logic ack;
    } pief_wb_state_t;

    pief_wb_state_t s_q;
    pief_wb_state_t s_d;

    // Access is taken once per request; ack drops the cycle after it rose
    assign acc_o = wb_cyc_i & wb_stb_i & ~s_q.ack;
    assign sel_reg_o = pief_decode(wb_adr_i);
    assign wb_ack_o = s_q.ack;

    always_comb begin
        s_d = s_q;
        s_d.ack = acc_o;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule : pief_wb_slave

`default_nettype wire

// >>> verilog/pief_flag_bank.sv
`default_nettype none

module pief_flag_bank
    import pief_pkg::*;
(
    input wire logic clk_i,          // Core clock
    input wire logic rst_i,          // Synchronous reset
    input wire logic [7:0] set_i,    // Hardware set, per bit
    input wire logic wr_i,           // Software load
    input wire logic [7:0] wdata_i,  // Software load value
    input wire logic rdclr_i,        // Clear all on read
    output logic [7:0] flags_o       // Flag state
);

    typedef struct packed {
        logic [7:0] flags;
    } pief_flag_state_t;

    pief_flag_state_t s_q;
    pief_flag_state_t s_d;

    always_comb begin
        s_d = s_q;
        if (wr_i) begin
            s_d.flags = wdata_i;
        end else if (rdclr_i) begin
            s_d.flags = 8'h00;
        end
        // Set wins over any clear in the same cycle
        s_d.flags = (s_d.flags | set_i) & PIEF_SOURCE_MASK;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q.flags <= PIEF_RST_PENDING;
        end else begin
            s_q <= s_d;
        end
    end

    assign flags_o = s_q.flags;

endmodule : pief_flag_bank

`default_nettype wire

// >>> verilog/pief_top.sv
// Implementation choice: the Wishbone slave port.
`default_nettype none

module pief_top
    import pief_pkg::*;
(
    input wire logic clk_i,           // Core clock, 100 MHz
    input wire logic rst_i,           // Synchronous reset, active high
    input wire logic wb_cyc_i,        // Wishbone cycle
    input wire logic wb_stb_i,        // Wishbone strobe
    input wire logic wb_we_i,         // Wishbone write enable
    input wire logic [7:0] wb_adr_i,  // Wishbone byte address
    input wire logic [3:0] wb_sel_i,  // Wishbone byte selects
    input wire logic [31:0] wb_dat_i, // Wishbone write data
    output logic [31:0] wb_dat_o,     // Wishbone read data
    output logic wb_ack_o,            // Wishbone acknowledge
    input wire logic evt_parallel_i,  // Parallel port read/write event
    input wire logic evt_serial_rx_i, // Serial receive event
    input wire logic evt_serial_tx_i, // Serial transmit event
    input wire logic evt_sync_serial_i, // Sync serial event
    input wire logic evt_capcmp_i,    // Capture/compare event
    input wire logic evt_period_match_i, // Timer period match event
    input wire logic evt_overflow_i,  // Timer overflow event
    output logic core_irq_o,          // Peripheral request to the core
    output logic evt_irq_o            // Masked event status interrupt
);

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [7:0] enable;
        logic [7:0] control;
        logic [7:0] evt_mask;
        logic [7:0] rdata;
        logic core_irq;
    } pief_top_state_t;

    pief_top_state_t s_q;
    pief_top_state_t s_d;

    logic acc;
    pief_reg_t sel_reg;
    logic wr_lane0;
    logic rd_acc;
    logic [7:0] src_evt;
    logic [7:0] pending;
    logic [7:0] evt_status;
    logic pend_wr;
    logic stat_rdclr;
    logic periph_req;

    ////////////////////////////////////////////////////////////////////////
    // Bus front end

    pief_wb_slave u_wb (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_adr_i(wb_adr_i),
        .wb_ack_o(wb_ack_o),
        .acc_o(acc),
        .sel_reg_o(sel_reg)
    );

    // Registers are eight bits wide, so only lane 0 writes
    assign wr_lane0 = acc & wb_we_i & wb_sel_i[0];
    assign rd_acc = acc & ~wb_we_i;

    ////////////////////////////////////////////////////////////////////////
    // Event sources

    always_comb begin
        src_evt = 8'h00;
        src_evt[PIEF_BIT_PARALLEL] = evt_parallel_i;
        src_evt[PIEF_BIT_SERIAL_RX] = evt_serial_rx_i;
        src_evt[PIEF_BIT_SERIAL_TX] = evt_serial_tx_i;
        src_evt[PIEF_BIT_SYNC_SERIAL] = evt_sync_serial_i;
        src_evt[PIEF_BIT_CAPCMP] = evt_capcmp_i;
        src_evt[PIEF_BIT_PERIOD_MATCH] = evt_period_match_i;
        src_evt[PIEF_BIT_OVERFLOW] = evt_overflow_i;
    end

    ////////////////////////////////////////////////////////////////////////
    // Pending flags

    assign pend_wr = wr_lane0 && (sel_reg == PIEF_REG_PENDING);

    pief_flag_bank u_pending (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(src_evt),
        .wr_i(pend_wr),
        .wdata_i(wb_dat_i[7:0]),
        .rdclr_i(1'b0),
        .flags_o(pending)
    );

    ////////////////////////////////////////////////////////////////////////
    // Event status, cleared by reading it

    assign stat_rdclr = rd_acc && (sel_reg == PIEF_REG_EVT_STATUS);

    pief_flag_bank u_evt_status (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(src_evt),
        .wr_i(1'b0),
        .wdata_i(8'h00),
        .rdclr_i(stat_rdclr),
        .flags_o(evt_status)
    );

    ////////////////////////////////////////////////////////////////////////
    // Request gating

    // Reserved slot has no flag, so its enable does nothing
    assign periph_req = |(pending & s_q.enable & PIEF_SOURCE_MASK)
        & s_q.control[PIEF_BIT_PERIPH_MASTER_EN]
        & s_q.control[PIEF_BIT_GLOBAL_EN];

    ////////////////////////////////////////////////////////////////////////
    // Registers

    always_comb begin
        s_d = s_q;
        s_d.core_irq = periph_req;
        if (wr_lane0) begin
            case (sel_reg)
                PIEF_REG_ENABLE: begin
                    s_d.enable = wb_dat_i[7:0];
                end
                PIEF_REG_CONTROL: begin
                    s_d.control = wb_dat_i[7:0] & PIEF_CONTROL_MASK;
                end
                PIEF_REG_EVT_MASK: begin
                    s_d.evt_mask = wb_dat_i[7:0] & PIEF_SOURCE_MASK;
                end
                default: begin
                end
            endcase
        end
        if (rd_acc) begin
            case (sel_reg)
                PIEF_REG_PENDING: begin
                    s_d.rdata = pending;
                end
                PIEF_REG_ENABLE: begin
                    s_d.rdata = s_q.enable;
                end
                PIEF_REG_CONTROL: begin
                    s_d.rdata = s_q.control;
                end
                PIEF_REG_EVT_STATUS: begin
                    s_d.rdata = evt_status;
                end
                PIEF_REG_EVT_MASK: begin
                    s_d.rdata = s_q.evt_mask;
                end
                default: begin
                    s_d.rdata = 8'h00;
                end
            endcase
        end else if (acc) begin
            // Writes answer with zero data
            s_d.rdata = 8'h00;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q.enable <= PIEF_RST_ENABLE;
            s_q.control <= PIEF_RST_CONTROL;
            s_q.evt_mask <= PIEF_RST_EVT_MASK;
            s_q.rdata <= 8'h00;
            s_q.core_irq <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign wb_dat_o = {24'h000000, s_q.rdata};
    assign core_irq_o = s_q.core_irq;
    assign evt_irq_o = |(evt_status & s_q.evt_mask);

endmodule : pief_top

`default_nettype wire

// >>> sim/pief_top_chk.sv
`default_nettype none
module pief_top_chk (
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Reset
    input wire logic wb_cyc_i, // Cycle
    input wire logic wb_stb_i, // Strobe
    input wire logic wb_we_i, // Write
    input wire logic [31:0] wb_dat_o, // Read data
    input wire logic wb_ack_o, // Ack
    input wire logic evt_parallel_i, // Event
    input wire logic evt_serial_rx_i, // Event
    input wire logic evt_serial_tx_i, // Event
    input wire logic evt_sync_serial_i, // Event
    input wire logic evt_capcmp_i, // Event
    input wire logic evt_period_match_i, // Event
    input wire logic evt_overflow_i, // Event
    input wire logic core_irq_o, // Core irq
    input wire logic evt_irq_o // Status irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic acc;
    logic wr;
    logic ev;
    assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = acc && wb_we_i;
    assign ev = evt_parallel_i || evt_serial_rx_i || evt_serial_tx_i || evt_sync_serial_i
        || evt_capcmp_i || evt_period_match_i || evt_overflow_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack_resp; acc |=> wb_ack_o; endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("no ack");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
    property p_no_ack; !wb_cyc_i |=> !wb_ack_o; endproperty
    a_no_ack: assert property (p_no_ack) else $error("stray ack");
    property p_dat_hi; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
    a_dat_hi: assert property (p_dat_hi) else $error("upper data set");
    // Pending flags only clear on a bus write; events can only set them
    property p_irq_hold; core_irq_o && !$past(wr) && !wr |=> core_irq_o; endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
    property p_irq_rise;
        $rose(core_irq_o) |-> $past(ev, 2) || $past(wr, 2) || $past(ev) || $past(wr);
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq no cause");
    property p_evt_rise; $rose(evt_irq_o) |-> $past(ev) || $past(wr); endproperty
    a_evt_rise: assert property (p_evt_rise) else $error("status irq no cause");
    property p_evt_hold; evt_irq_o && !acc |=> evt_irq_o; endproperty
    a_evt_hold: assert property (p_evt_hold) else $error("status irq dropped");
endmodule : pief_top_chk
`default_nettype wire

// >>> sim/pief_evt_src.sv
`default_nettype none
module pief_evt_src (
    input wire logic clk_i, // Clock
    input wire logic [7:0] fire_i, // Sources to raise
    input wire logic [1:0] hold_i, // Extra cycles
    output logic [7:0] evt_o // Event lines
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] evt_q = 8'h00;
    logic [1:0] cnt_q = 2'h0;
    assign evt_o = evt_q;
    // Slow sources hold the condition a few cycles; idle lines sit low
    always @(posedge clk_i) begin
        if (fire_i != 8'h00) begin
            evt_q <= fire_i;
            cnt_q <= hold_i;
        end else if (cnt_q != 2'h0) begin
            cnt_q <= cnt_q - 2'h1;
        end else begin
            evt_q <= 8'h00;
        end
    end
endmodule : pief_evt_src
`default_nettype wire

// >>> sim/peripheral_irq_enable_flags_tb.sv
`default_nettype none
module peripheral_irq_enable_flags_tb import pief_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00, fire = 8'h00, last;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, lfsr_q = 32'h59f9;
    logic [1:0] hold = 2'h0;
    logic ack, core_irq, evt_irq;
    logic [7:0] evt;
    int n_fail = 0, cmp_count = 0, cyc_cnt = 0;
    pief_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .evt_parallel_i(evt[7]), .evt_serial_rx_i(evt[5]),
        .evt_serial_tx_i(evt[4]), .evt_sync_serial_i(evt[3]), .evt_capcmp_i(evt[2]),
        .evt_period_match_i(evt[1]), .evt_overflow_i(evt[0]), .core_irq_o(core_irq),
        .evt_irq_o(evt_irq));
    pief_evt_src i_src (.clk_i(clk_i), .fire_i(fire), .hold_i(hold), .evt_o(evt));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic s);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        sel <= {3'h0, s};
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        last = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 1'b1);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00, 1'b1);
        chk(last, e);
    endtask : rd
    task automatic pulse(input logic [7:0] v);
        fire <= v;
        hold <= lfsr_q[1:0];
        lfsr_q = lfsr(lfsr_q);
        @(posedge clk_i);
        fire <= 8'h00;
        repeat (6) @(posedge clk_i);
    endtask : pulse
    task automatic irq(input logic e);
        @(posedge clk_i);
        chk({7'h0, core_irq}, {7'h0, e});
    endtask : irq
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 5000) begin
            n_fail++;
            stop_test();
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] v;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(PIEF_ADR_ENABLE, 8'h00);
        rd(PIEF_ADR_PENDING, 8'h00);
        irq(1'b0);
        $display("reset test ends");
        for (int i = 0; i < 8; i++) begin
            v = lfsr_q[7:0] & 8'hbf;
            lfsr_q = lfsr(lfsr_q);
            wr(PIEF_ADR_ENABLE, v);
            bus(1'b1, PIEF_ADR_ENABLE, ~v & 8'hbf, 1'b0);
            rd(PIEF_ADR_ENABLE, v);
        end
        wr(8'h40, 8'hff);
        rd(8'h40, 8'h00);
        $display("enable test ends");
        for (int b = 0; b < 8; b++) begin
            v = 8'h01 << b;
            wr(PIEF_ADR_CONTROL, 8'h00);
            wr(PIEF_ADR_PENDING, 8'h00);
            pulse(v & 8'hbf);
            rd(PIEF_ADR_PENDING, v & 8'hbf);
            wr(PIEF_ADR_ENABLE, v & 8'hbf);
            wr(PIEF_ADR_CONTROL, 8'h80);
            irq(1'b0);
            wr(PIEF_ADR_CONTROL, 8'h40);
            irq(1'b0);
            wr(PIEF_ADR_CONTROL, 8'hc0);
            irq(b != PIEF_BIT_RESERVED);
            wr(PIEF_ADR_ENABLE, ~v & 8'hbf);
            irq(1'b0);
            wr(PIEF_ADR_ENABLE, v & 8'hbf);
            rd(PIEF_ADR_PENDING, v & 8'hbf);
            wr(PIEF_ADR_PENDING, 8'h00);
            irq(1'b0);
        end
        wr(PIEF_ADR_CONTROL, 8'hff);
        rd(PIEF_ADR_CONTROL, 8'hc0);
        wr(PIEF_ADR_PENDING, 8'h40);
        rd(PIEF_ADR_PENDING, 8'h00);
        $display("source test ends");
        chk({7'h0, evt_irq}, 8'h00);
        rd(PIEF_ADR_EVT_STATUS, 8'hbf);
        rd(PIEF_ADR_EVT_STATUS, 8'h00);
        v = 8'h01 << lfsr_q[1:0];
        pulse(v);
        chk({7'h0, evt_irq}, 8'h00);
        wr(PIEF_ADR_EVT_MASK, v);
        rd(PIEF_ADR_EVT_MASK, v);
        chk({7'h0, evt_irq}, 8'h01);
        rd(PIEF_ADR_EVT_STATUS, v);
        chk({7'h0, evt_irq}, 8'h00);
        $display("status test ends");
        stop_test();
    end
endmodule : peripheral_irq_enable_flags_tb
bind pief_top pief_top_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .evt_parallel_i(evt_parallel_i), .evt_serial_rx_i(evt_serial_rx_i),
    .evt_serial_tx_i(evt_serial_tx_i), .evt_sync_serial_i(evt_sync_serial_i),
    .evt_capcmp_i(evt_capcmp_i), .evt_period_match_i(evt_period_match_i),
    .evt_overflow_i(evt_overflow_i), .core_irq_o(core_irq_o), .evt_irq_o(evt_irq_o));
`default_nettype wire
